// File: hdl/fwpm_top.v
// Purpose: Watchdog timer, oscillator monitor and power-saving mode control
// Assumes: Inputs synchronous to ref_clk; AHB-Lite slave, single words
// Notes: Bus writes to control regs stand in for CPU instructions
`timescale 1ns/100ps
`default_nettype none
`include "fwpm_defs.vh"

// Overview of operation
// - Watchdog is a 15-bit up-counter; its overflow is the time-out.
// - Counter advances at clock divided by 12 or 384, selectable.
// - Only the upper 7 counter bits are programmable by software.
// - Watchdog starts by software start bit or hardware enable pin.
// - Once running in active mode, only a reset can stop the watchdog.
// - Overflow without refresh raises an internal reset.
// - Valid refresh copies reload value into upper 7 counter bits.
// - Refresh is refresh-bit write immediately followed by start-bit write.
// - Flag shows whether last reset came from pin or watchdog.
// - Watchdog counter frozen in idle and power-down.
// - Slow main oscillator selects RC clock and holds reset.
// - After failure clears, reset extended about 0.5 ms then released.
// - Leaving power-down, oscillator start-up supervised the same way.
// - At power-on reset logic runs on RC clock before main oscillator.
// - Idle gates only the CPU clock; enabled peripherals keep running.
// - Power-down stops everything and turns oscillator off, RAM kept.
// - Power-down entered by software command or hardware pin.
// - Slow-down divides CPU and peripheral clock by eight.
// - Idle left by interrupt keeps CPU, port and peripheral state.
// - Any mode left by hardware reset restores the full reset state.
// - In idle only enabled peripherals run; CPU keeps its data.
module fwpm_top #(
    parameter STAB_CYC = (`FWPM_STAB_NS + `FWPM_CLK_NS - 1) / `FWPM_CLK_NS
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Pins and system signals
    input wire hw_wdog_enable_pin,
    input wire hw_powerdown_pin,
    input wire osc_slow,
    input wire periph_irq,
    input wire periph_en,
    // Clock and reset controls
    output wire osc_enable,
    output wire clk_sel_rc,
    output wire cpu_clk_en,
    output wire periph_clk_en,
    output wire sys_reset,
    output reg wdog_reset
);
    localparam [1:0] OM_RUN = 2'd0;
    localparam [1:0] OM_FAIL = 2'd1;
    localparam [1:0] OM_STAB = 2'd2;
    localparam [19:0] STAB_MAX = STAB_CYC[19:0] - 20'h00001;

    // High while the oscillator monitor holds the core in reset
    function osc_hold;
        input [1:0] state;
        begin
            osc_hold = (state != OM_RUN);
        end
    endfunction

    // Write data phase aimed at one register offset
    function wr_hit;
        input phase;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_hit = phase && (addr == ofs);
        end
    endfunction

    // Prescaler length for the selected rate
    function [8:0] div_of;
        input slow;
        begin
            div_of = slow ? `FWPM_DIV_SLOW : `FWPM_DIV_FAST;
        end
    endfunction

    reg [14:0] wdog_cnt;
    reg [6:0] wdog_reload_value;
    reg presc_slow;
    reg [8:0] presc;
    reg wdog_run;
    reg wdog_refresh_bit;
    reg wdog_reset_cause_flag;
    reg idle_armed, idle_mode, pd_mode, slow_mode;
    reg [2:0] slow_cnt;
    reg [1:0] om_state;
    reg [19:0] stab_cnt;
    reg hw_pd_q;
    // Address phase capture
    reg wr_ph, rd_ph;
    reg [7:0] ph_addr;

    wire acc = hsel && hready && htrans[1];
    wire wr_ctl = wr_hit(wr_ph, ph_addr, `FWPM_OFS_WDCTL);
    wire wr_rel = wr_hit(wr_ph, ph_addr, `FWPM_OFS_WDREL);
    wire wr_pwr = wr_hit(wr_ph, ph_addr, `FWPM_OFS_PWR);
    wire any_wr = wr_ph;
    wire frozen = idle_mode || pd_mode;
    wire slow_tick = !slow_mode || slow_cnt == `FWPM_SLOW_DIV;
    wire [8:0] div_sel = div_of(presc_slow);
    wire presc_end = presc == div_sel - 9'd1;
    wire wd_tick = wdog_run && !frozen && slow_tick && presc_end;
    wire wd_ovf = wd_tick && wdog_cnt == 15'h7fff;
    wire refresh_ok = wr_ctl && wdog_refresh_bit &&
                      hwdata[`FWPM_B_START];
    wire stab_done = stab_cnt == STAB_MAX;
    wire core_rst = osc_hold(om_state) || wdog_reset;
    wire start_req = wr_ctl && hwdata[`FWPM_B_START];
    wire pwr_clr = core_rst && !pd_mode;
    wire idle_go = wr_pwr && idle_armed && hwdata[`FWPM_B_IDLE2] &&
                   !hwdata[`FWPM_B_IDLE1];

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign sys_reset = core_rst;
    assign clk_sel_rc = osc_hold(om_state);
    assign osc_enable = !pd_mode;
    assign cpu_clk_en = !idle_mode && !pd_mode && slow_tick;
    assign periph_clk_en = !pd_mode && periph_en && slow_tick;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ph <= 1'b0;
            rd_ph <= 1'b0;
            ph_addr <= 8'h00;
        end else begin
            wr_ph <= acc && hwrite;
            rd_ph <= acc && !hwrite;
            if (acc) begin
                ph_addr <= haddr;
            end
        end
    end

    // Read-back value of one register offset
    function [31:0] read_mux;
        input [7:0] addr;
        begin
            case (addr)
                `FWPM_OFS_WDREL: begin
                    read_mux = {24'h000000, presc_slow, wdog_reload_value};
                end
                `FWPM_OFS_PWR: begin
                    read_mux = {27'h0, slow_mode, 4'h0};
                end
                `FWPM_OFS_STAT: begin
                    read_mux = {27'h0, osc_hold(om_state), pd_mode,
                        idle_mode, wdog_run,
                        wdog_reset_cause_flag};
                end
                `FWPM_OFS_CNT: begin
                    read_mux = {17'h0, wdog_cnt};
                end
                default: begin
                    read_mux = 32'h00000000;
                end
            endcase
        end
    endfunction

    // Read data, one cycle after the address phase
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h00000000;
        end else if (acc && !hwrite) begin
            hrdata <= read_mux(haddr);
        end
    end

    // Reload value and prescaler select
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_reload_value <= 7'h00;
            presc_slow <= 1'b0;
        end else if (core_rst) begin
            wdog_reload_value <= 7'h00;
            presc_slow <= 1'b0;
        end else if (wr_rel) begin
            wdog_reload_value <= hwdata[6:0];
            presc_slow <= hwdata[`FWPM_B_PRESC];
        end
    end

    // Prescaler, stopped together with the counter
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc <= 9'h000;
        end else if (core_rst) begin
            presc <= 9'h000;
        end else if (!frozen && slow_tick && wdog_run) begin
            if (presc_end) begin
                presc <= 9'h000;
            end else begin
                presc <= presc + 9'd1;
            end
        end
    end

    // Run flag: set by bit or pin, cleared only by reset
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_run <= 1'b0;
        end else if (core_rst) begin
            wdog_run <= 1'b0;
        end else if (start_req || hw_wdog_enable_pin) begin
            wdog_run <= 1'b1;
        end
    end

    // Refresh flag lives for exactly one following write
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_refresh_bit <= 1'b0;
        end else if (core_rst) begin
            wdog_refresh_bit <= 1'b0;
        end else if (any_wr) begin
            wdog_refresh_bit <= wr_ctl && hwdata[`FWPM_B_REFRESH] &&
                !hwdata[`FWPM_B_START];
        end
    end

    // Watchdog counter
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_cnt <= 15'h0000;
        end else if (core_rst) begin
            wdog_cnt <= 15'h0000;
        end else if (refresh_ok) begin
            wdog_cnt <= {wdog_reload_value, 8'h00};
        end else if (wd_tick) begin
            wdog_cnt <= wdog_cnt + 15'd1;
        end
    end

    // Overflow pulse, one cycle long
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_reset <= 1'b0;
        end else if (core_rst) begin
            wdog_reset <= 1'b0;
        end else begin
            wdog_reset <= wd_ovf;
        end
    end

    // Cause flag survives its own watchdog reset
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_reset_cause_flag <= 1'b0;
        end else if (osc_hold(om_state)) begin
            wdog_reset_cause_flag <= 1'b0;
        end else if (!wdog_reset && wd_ovf) begin
            wdog_reset_cause_flag <= 1'b1;
        end
    end

    // Power-down pin delayed one cycle for its falling edge
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_pd_q <= 1'b0;
        end else begin
            hw_pd_q <= hw_powerdown_pin;
        end
    end

    // Slow-down phase counter
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_cnt <= 3'h0;
        end else if (pwr_clr) begin
            slow_cnt <= 3'h0;
        end else begin
            slow_cnt <= slow_cnt + 3'd1;
        end
    end

    // Slow-down select
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_mode <= 1'b0;
        end else if (pwr_clr) begin
            slow_mode <= 1'b0;
        end else if (wr_pwr) begin
            slow_mode <= hwdata[`FWPM_B_SLOW];
        end
    end

    // First half of the idle pair, dropped by any other write
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_armed <= 1'b0;
        end else if (pwr_clr) begin
            idle_armed <= 1'b0;
        end else if (any_wr) begin
            idle_armed <= wr_pwr && hwdata[`FWPM_B_IDLE1] &&
                !hwdata[`FWPM_B_IDLE2];
        end
    end

    // Idle: a wake-up only acts once in idle, so an entry wins over a same-cycle wake-up
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_mode <= 1'b0;
        end else if (pwr_clr) begin
            idle_mode <= 1'b0;
        end else if (periph_irq && idle_mode) begin
            idle_mode <= 1'b0;
        end else if (idle_go) begin
            idle_mode <= 1'b1;
        end
    end

    // Power-down, left only by pin release or reset
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_mode <= 1'b0;
        end else if (pwr_clr) begin
            pd_mode <= 1'b0;
        end else if (hw_powerdown_pin) begin
            pd_mode <= 1'b1;
        end else if (hw_pd_q) begin
            pd_mode <= 1'b0;
        end else if (wr_pwr && hwdata[`FWPM_B_PD]) begin
            pd_mode <= 1'b1;
        end
    end

    // Oscillator monitor
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            om_state <= OM_FAIL;
            stab_cnt <= 20'h00000;
        end else begin
            case (om_state)
                OM_RUN: begin
                    stab_cnt <= 20'h00000;
                    if ((osc_slow && !pd_mode) ||
                        (hw_pd_q && !hw_powerdown_pin))
                        om_state <= OM_FAIL;
                end
                OM_FAIL: begin
                    stab_cnt <= 20'h00000;
                    if (!osc_slow && !pd_mode)
                        om_state <= OM_STAB;
                end
                OM_STAB: begin
                    if (osc_slow)
                        om_state <= OM_FAIL;
                    else if (stab_done)
                        om_state <= OM_RUN;
                    else
                        stab_cnt <= stab_cnt + 20'd1;
                end
                default: om_state <= OM_FAIL;
            endcase
        end
    end
endmodule // fwpm_top
`default_nettype wire

// File: hdl/fwpm_defs.vh
// Purpose: Constants for the fail-safe watchdog and power-mode block
// Assumes: 32-bit AHB-Lite register bus, 100 MHz ref_clk
// Notes: Byte offsets of word-aligned registers
`ifndef FWPM_DEFS_VH
`define FWPM_DEFS_VH
`define FWPM_OFS_WDCTL 8'h00
`define FWPM_OFS_WDREL 8'h04
`define FWPM_OFS_PWR 8'h08
`define FWPM_OFS_STAT 8'h0c
`define FWPM_OFS_CNT 8'h10
// Watchdog control bits
`define FWPM_B_REFRESH 0
`define FWPM_B_START 1
// Reload register bits
`define FWPM_B_PRESC 7
// Power control bits
`define FWPM_B_IDLE1 0
`define FWPM_B_PD 1
`define FWPM_B_SLOW 4
`define FWPM_B_IDLE2 5
// Status bits
`define FWPM_B_CAUSE 0
`define FWPM_B_RUN 1
`define FWPM_B_IDLE 2
`define FWPM_B_PDS 3
`define FWPM_B_OSCF 4
// Prescaler divides and slow-down count
`define FWPM_DIV_FAST 9'd12
`define FWPM_DIV_SLOW 9'd384
`define FWPM_SLOW_DIV 3'd7
// Stabilisation time
`define FWPM_STAB_NS 500000
`define FWPM_CLK_NS 10
`endif

// File: verif/fwpm_properties.sv
// Purpose: Port assertions for fwpm_top
// Assumes: One clock domain, reset active low
// Notes: Bound to every fwpm_top instance
`timescale 1ns/100ps
`default_nettype none
module fwpm_properties #(
    parameter STAB_CYC = 10
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Pins
    input wire logic hw_powerdown_pin,
    input wire logic osc_slow,
    input wire logic periph_en,
    // Clock and reset controls
    input wire logic osc_enable,
    input wire logic clk_sel_rc,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic sys_reset,
    input wire logic wdog_reset
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Oscillator good and no power-down for 17 samples
    sequence s_clear;
        $fell(osc_slow) && !hw_powerdown_pin ##1
        (!osc_slow && !hw_powerdown_pin)[*8] ##1
        (!osc_slow && !hw_powerdown_pin)[*8];
    endsequence
    sequence s_pd;
        hw_powerdown_pin[*2];
    endsequence
    chk_fail_rc: assert property (
        osc_slow |-> ##[1:2] (clk_sel_rc && sys_reset))
        else $error("rc clock or reset missing in osc failure");
    chk_stab_hold: assert property ($fell(osc_slow) |-> sys_reset[*8])
        else $error("reset released early after osc failure");
    chk_stab_end: assert property (s_clear |-> !clk_sel_rc)
        else $error("monitor did not return to run");
    chk_rc_reset: assert property (clk_sel_rc |-> sys_reset)
        else $error("rc clock selected without reset");
    chk_wdog_pulse: assert property (
        $rose(wdog_reset) |-> sys_reset ##1 !wdog_reset)
        else $error("watchdog reset pulse malformed");
    chk_pd_stop: assert property (
        s_pd |-> !osc_enable && !cpu_clk_en && !periph_clk_en)
        else $error("clocks still running in power-down");
    chk_pd_restart: assert property (
        $fell(hw_powerdown_pin) |-> ##[0:2] clk_sel_rc)
        else $error("no supervised restart after power-down");
    chk_periph_off: assert property (!periph_en |-> !periph_clk_en)
        else $error("disabled peripherals still clocked");
endmodule // fwpm_properties
bind fwpm_top fwpm_properties #(.STAB_CYC(STAB_CYC)) i_fwpm_properties (
    .ref_clk(ref_clk), .rst_n(rst_n), .hw_powerdown_pin(hw_powerdown_pin),
    .osc_slow(osc_slow), .periph_en(periph_en), .osc_enable(osc_enable),
    .clk_sel_rc(clk_sel_rc), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .sys_reset(sys_reset),
    .wdog_reset(wdog_reset));
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Directed bench for fwpm_top over AHB-Lite
// Assumes: Zero-wait slave, STAB_CYC of 10
// Notes: Offsets and bits as in the design header
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hwdata = 32'h0, rd, c0;
    logic wd_pin = 1'b0, pd_pin = 1'b0, slow = 1'b0, irq = 1'b0, pen = 1'b1;
    wire hrdy, hresp, osc_en, rc, cpu_en, per_en, sys_rst, wd_rst;
    wire [31:0] hrdata;
    int n_mismatch = 0, total_checks = 0, cyc = 0, k, a, b;
    fwpm_top #(.STAB_CYC(10)) i_fwpm_top (.ref_clk(ref_clk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
        .hresp(hresp), .hrdata(hrdata), .hw_wdog_enable_pin(wd_pin),
        .hw_powerdown_pin(pd_pin), .osc_slow(slow), .periph_irq(irq),
        .periph_en(pen), .osc_enable(osc_en), .clk_sel_rc(rc),
        .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .sys_reset(sys_rst),
        .wdog_reset(wd_rst));
    always #5 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] got, exp, input string nm);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic [7:0] ad, input logic w, logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= ad;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge ref_clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hrdy !== 1'b1);
        rd = hrdata;
        chk(hresp, 1'b0, "response");
    endtask
    task automatic wait_run(output int n);
        n = 0;
        while (rc !== 1'b0 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    // Counter ticks over a wait must match the divide
    task automatic rate(input logic [31:0] rel, input int w, e);
        xfer(8'h04, 1'b1, rel);
        xfer(8'h10, 1'b0, 32'h0);
        c0 = rd;
        repeat (w) @(posedge ref_clk);
        xfer(8'h10, 1'b0, 32'h0);
        chk(32'(rd - c0 - e <= 1), 1, "tick rate");
    endtask
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_run(k);
        chk(32'(k >= 10 && k <= 13), 1, "power-on stab");
        xfer(8'h0c, 1'b0, 32'h0);
        chk(rd, 32'h0, "status at start");
        xfer(8'h3c, 1'b0, 32'h0);
        chk(rd, 32'h0, "unmapped");
        slow <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk({rc, sys_rst}, 2'b11, "osc fail");
        @(posedge ref_clk);
        slow <= 1'b0;
        wait_run(k);
        chk(32'(k >= 10 && k <= 13), 1, "stab time");
        xfer(8'h04, 1'b1, 32'h7f);
        xfer(8'h04, 1'b0, 32'h0);
        chk(rd, 32'h7f, "reload");
        xfer(8'h00, 1'b1, 32'h1);
        xfer(8'h00, 1'b1, 32'h2);
        xfer(8'h10, 1'b0, 32'h0);
        chk(rd[14:8], 7'h7f, "refresh load");
        rate(32'h7f, 117, 10);
        rate(32'hff, 3837, 10);
        xfer(8'h00, 1'b1, 32'h1);
        xfer(8'h04, 1'b1, 32'h20);
        xfer(8'h00, 1'b1, 32'h2);
        xfer(8'h10, 1'b0, 32'h0);
        chk(rd[14:8], 7'h7f, "broken pair");
        xfer(8'h00, 1'b1, 32'h0);
        xfer(8'h0c, 1'b0, 32'h0);
        chk(rd[1], 1'b1, "no stop");
        xfer(8'h08, 1'b1, 32'h1);
        xfer(8'h08, 1'b1, 32'h20);
        xfer(8'h0c, 1'b0, 32'h0);
        chk(rd[2], 1'b1, "idle entered");
        chk({cpu_en, per_en}, 2'b01, "idle gating");
        xfer(8'h10, 1'b0, 32'h0);
        c0 = rd;
        pen <= 1'b0;
        repeat (100) @(posedge ref_clk);
        chk(per_en, 1'b0, "idle periph off");
        pen <= 1'b1;
        xfer(8'h10, 1'b0, 32'h0);
        chk(rd, c0, "idle freeze");
        irq <= 1'b1;
        @(posedge ref_clk);
        irq <= 1'b0;
        @(negedge ref_clk);
        chk(cpu_en, 1'b1, "idle wake");
        xfer(8'h08, 1'b1, 32'h20);
        @(negedge ref_clk);
        chk(cpu_en, 1'b1, "lone write");
        xfer(8'h08, 1'b1, 32'h10);
        xfer(8'h08, 1'b0, 32'h0);
        chk(rd, 32'h10, "slow readback");
        a = 0;
        b = 0;
        repeat (80) begin
            @(negedge ref_clk);
            a += cpu_en;
            b += per_en;
        end
        chk(32'(a * 100 + b), 32'd1010, "slow-down");
        xfer(8'h08, 1'b1, 32'h0);
        xfer(8'h04, 1'b1, 32'h7f);
        xfer(8'h00, 1'b1, 32'h1);
        xfer(8'h00, 1'b1, 32'h2);
        k = 0;
        while (wd_rst !== 1'b1 && k < 4000) begin
            @(negedge ref_clk);
            k++;
        end
        chk(32'(k >= 3040 && k <= 3090), 1, "overflow time");
        xfer(8'h0c, 1'b0, 32'h0);
        chk(rd, 32'h1, "watchdog cause");
        wd_pin <= 1'b1;
        xfer(8'h0c, 1'b0, 32'h0);
        chk(rd[1], 1'b1, "pin start");
        wd_pin <= 1'b0;
        pd_pin <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk({osc_en, cpu_en}, 2'b00, "pin power-down");
        @(posedge ref_clk);
        pd_pin <= 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(rc, 1'b1, "pd restart");
        wait_run(k);
        xfer(8'h0c, 1'b0, 32'h0);
        chk(rd[1], 1'b0, "pd clears wdog");
        xfer(8'h08, 1'b1, 32'h2);
        @(negedge ref_clk);
        chk(osc_en, 1'b0, "soft power-down");
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_run(k);
        xfer(8'h0c, 1'b0, 32'h0);
        chk(rd, 32'h0, "reset state");
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
